// ===== inc/ces_consts.svh
`ifndef CES_CONSTS_SVH
`define CES_CONSTS_SVH

// reset vector table slots (no base added)
`define CES_PO_PC_ADDR   32'h00000000
`define CES_PO_SP_ADDR   32'h00000004
`define CES_MR_PC_ADDR   32'h00000008
`define CES_MR_SP_ADDR   32'h0000000C

// vector numbers of the fixed sources
`define CES_VEC_GEN_ILL  8'h04
`define CES_VEC_SLOT_ILL 8'h06
`define CES_VEC_CPU_AERR 8'h09
`define CES_VEC_XFR_AERR 8'h0A
`define CES_VEC_NMI      8'h0B
`define CES_VEC_UBRK     8'h0C
`define CES_VEC_IRQ_BASE 8'h40

// interrupt source kinds from the interrupt controller
`define CES_INT_NMI      2'h0
`define CES_INT_UBRK     2'h1
`define CES_INT_LINE     2'h2
`define CES_INT_PERIPH   2'h3

// status word layout and reset values
`define CES_MASK_HI      7
`define CES_MASK_LO      4
`define CES_MASK_ALL     4'hF
`define CES_SW_RESET     32'h000000F0
`define CES_VBR_RESET    32'h00000000
`define CES_SP_STEP      32'h00000004

`endif

// ===== inc/ces_pkg.sv
package ces_pkg;
    // sequencer steps
    typedef enum logic [2:0] {
        CES_IDLE,
        CES_RST_HOLD,
        CES_RD_PC,
        CES_RD_SP,
        CES_PUSH_SW,
        CES_PUSH_PC,
        CES_RD_VEC
    } ces_state_t;

    // whole state of the sequencer
    typedef struct packed {
        ces_state_t  st;
        logic [31:0] vector_base_reg;
        logic [31:0] sp;
        logic [31:0] sw;
        logic [31:0] pc;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [7:0]  vec;
        logic [3:0]  lvl;
        logic        kind_irq;
        logic        kind_rst;
        logic        kind_manual_reset_pin_n;
        logic        mreq;
        logic        mwe;
        logic        ctx_load;
        logic        int_ack;
        logic        periph_rst;
        logic        po_prev;
        logic        mr_prev;
        logic        pend_cpu_ae;
        logic        pend_xfr_ae;
        logic        pend_irq;
    } ces_regs_t;
endpackage

// ===== design/ces_seq.sv
`timescale 1ns/100ps
`include "ces_consts.svh"

// Function
// - resets beat address errors, which beat interrupts, which beat instruction exceptions
// - trap beats general illegal, which beats slot illegal
// - power-on reset handling starts when its pin rises
// - manual reset starts when its pin rises while power-on pin high
// - address errors caught whenever signalled, interrupts caught at decode, both taken at instruction end
// - trap exception starts from executing the trap instruction
// - undefined opcode outside a delay slot gives general illegal
// - undefined or pc-changing opcode in delay slot gives slot illegal
// - power-on reset reads pc from 0 and sp from 4
// - manual reset reads pc from 8 and sp from C
// - reset clears the vector base register
// - reset sets the interrupt mask field to 1111
// - after reset, run from the fetched pc
// - other exceptions push status word and pc on the stack
// - interrupts write their level into the mask field
// - address error and instruction exceptions keep the mask field
// - then fetch handler address from vector table and run there
// - vector address is base plus four times vector; resets without base
// - power-on reset also resets peripherals; manual reset only the cpu
// - vectors: cpu aerr 9, transfer aerr 10, nmi 11, break 12, lines 64-71
module ces_seq
    import ces_pkg::*;
(
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESETN,
    // reset pins
    input  wire logic        I_POWER_ON_RESET_PIN_N,
    input  wire logic        I_MANUAL_RESET_PIN_N,
    // pipeline state and events
    input  wire logic        I_INSTR_DONE,
    input  wire logic        I_DECODE_VALID,
    input  wire logic        I_DECODE_UNDEFINED,
    input  wire logic        I_DECODE_IN_SLOT,
    input  wire logic        I_DECODE_PC_MODIFY,
    input  wire logic        I_TRAP_EXEC,
    input  wire logic [7:0]  I_TRAP_VECTOR,
    input  wire logic [31:0] I_RETURN_PC,
    input  wire logic [31:0] I_CPU_STATUS_WORD,
    input  wire logic [31:0] I_STACK_POINTER_GPR,
    input  wire logic        I_VBR_WE,
    input  wire logic [31:0] I_VBR_WDATA,
    // address error sources
    input  wire logic        I_CPU_ADDR_ERR,
    input  wire logic        I_XFER_ADDR_ERR,
    // interrupt controller
    input  wire logic        I_INT_REQ,
    input  wire logic [1:0]  I_INT_KIND,
    input  wire logic [2:0]  I_INT_LINE,
    input  wire logic [7:0]  I_INT_PERIPH_VEC,
    input  wire logic [3:0]  I_INT_LEVEL,
    output logic             O_INT_ACK,
    // memory bus
    output logic             O_MEM_REQ,
    output logic             O_MEM_WE,
    output logic [31:0]      O_MEM_ADDR,
    output logic [31:0]      O_MEM_WDATA,
    input  wire logic        I_MEM_ACK,
    input  wire logic [31:0] I_MEM_RDATA,
    // context handed back to the core
    output logic             O_BUSY,
    output logic             O_CPU_INIT,
    output logic             O_PERIPH_RESET,
    output logic             O_CTX_LOAD,
    output logic [31:0]      O_NEW_PC,
    output logic [31:0]      O_NEW_SP,
    output logic [31:0]      O_CPU_STATUS_WORD,
    output logic [31:0]      O_VECTOR_BASE_REG
);

    ces_regs_t   q;
    ces_regs_t   d;
    logic [7:0]  int_vec;
    logic [31:0] vec_off;
    logic        po_rise;
    logic        mr_rise;
    logic        take;

    // pin edges; pins count as synchronous here
    assign po_rise = !q.po_prev && I_POWER_ON_RESET_PIN_N;
    assign mr_rise = !q.mr_prev && I_MANUAL_RESET_PIN_N && I_POWER_ON_RESET_PIN_N;

    always_comb begin
        case (I_INT_KIND)
            `CES_INT_NMI:  int_vec = `CES_VEC_NMI;
            `CES_INT_UBRK: int_vec = `CES_VEC_UBRK;
            `CES_INT_LINE: int_vec = `CES_VEC_IRQ_BASE | {5'h00, I_INT_LINE};
            default:       int_vec = I_INT_PERIPH_VEC;
        endcase
    end

    // offset is four times the vector
    assign vec_off = {22'h000000, q.vec, 2'h0};

    // next state; clears come before sets so a new event is never lost
    always_comb begin
        d = q;
        d.ctx_load = 1'b0;
        d.int_ack = 1'b0;
        d.po_prev = I_POWER_ON_RESET_PIN_N;
        d.mr_prev = I_MANUAL_RESET_PIN_N;
        // explicit take flag; a repeat of the same vector must still be taken
        take = 1'b0;
        case (q.st)
            CES_IDLE: begin
                if ((q.pend_cpu_ae || q.pend_xfr_ae) && I_INSTR_DONE) begin
                    d.vec = q.pend_cpu_ae ? `CES_VEC_CPU_AERR : `CES_VEC_XFR_AERR;
                    if (q.pend_cpu_ae) begin
                        d.pend_cpu_ae = 1'b0;
                    end else begin
                        d.pend_xfr_ae = 1'b0;
                    end
                    d.kind_irq = 1'b0;
                    take = 1'b1;
                end else if (q.pend_irq && I_INT_REQ && I_INSTR_DONE) begin
                    d.vec = int_vec;
                    d.lvl = I_INT_LEVEL;
                    d.pend_irq = 1'b0;
                    d.int_ack = 1'b1;
                    d.kind_irq = 1'b1;
                    take = 1'b1;
                end else if (I_TRAP_EXEC) begin
                    d.vec = I_TRAP_VECTOR;
                    d.kind_irq = 1'b0;
                    take = 1'b1;
                end else if (I_DECODE_VALID && I_DECODE_UNDEFINED && !I_DECODE_IN_SLOT) begin
                    d.vec = `CES_VEC_GEN_ILL;
                    d.kind_irq = 1'b0;
                    take = 1'b1;
                end else if (I_DECODE_VALID && I_DECODE_IN_SLOT
                             && (I_DECODE_UNDEFINED || I_DECODE_PC_MODIFY)) begin
                    d.vec = `CES_VEC_SLOT_ILL;
                    d.kind_irq = 1'b0;
                    take = 1'b1;
                end
                if (take) begin
                    // first push is the status word at sp-4
                    d.kind_rst = 1'b0;
                    d.sw = I_CPU_STATUS_WORD;
                    d.pc = I_RETURN_PC;
                    d.sp = I_STACK_POINTER_GPR - `CES_SP_STEP;
                    d.addr = I_STACK_POINTER_GPR - `CES_SP_STEP;
                    d.wdata = I_CPU_STATUS_WORD;
                    d.mreq = 1'b1;
                    d.mwe = 1'b1;
                    d.st = CES_PUSH_SW;
                end
            end
            CES_PUSH_SW: begin
                if (I_MEM_ACK) begin
                    d.sp = q.sp - `CES_SP_STEP;
                    d.addr = q.sp - `CES_SP_STEP;
                    d.wdata = q.pc;
                    d.st = CES_PUSH_PC;
                end
            end
            CES_PUSH_PC: begin
                if (I_MEM_ACK) begin
                    d.mwe = 1'b0;
                    d.addr = q.vector_base_reg + vec_off;
                    d.st = CES_RD_VEC;
                end
            end
            CES_RD_VEC: begin
                if (I_MEM_ACK) begin
                    d.mreq = 1'b0;
                    d.pc = I_MEM_RDATA;
                    if (q.kind_irq) begin
                        d.sw[`CES_MASK_HI:`CES_MASK_LO] = q.lvl;
                    end
                    d.ctx_load = 1'b1;
                    d.st = CES_IDLE;
                end
            end
            CES_RD_PC: begin
                // sp slot follows the pc slot
                if (I_MEM_ACK) begin
                    d.pc = I_MEM_RDATA;
                    d.addr = q.kind_manual_reset_pin_n ? `CES_MR_SP_ADDR : `CES_PO_SP_ADDR;
                    d.st = CES_RD_SP;
                end
            end
            CES_RD_SP: begin
                if (I_MEM_ACK) begin
                    d.mreq = 1'b0;
                    d.sp = I_MEM_RDATA;
                    d.vector_base_reg = `CES_VBR_RESET;
                    d.sw = `CES_SW_RESET;
                    d.ctx_load = 1'b1;
                    d.st = CES_IDLE;
                end
            end
            CES_RST_HOLD: begin
                d.mreq = 1'b0;
                d.mwe = 1'b0;
            end
            default: begin
                d.st = CES_RST_HOLD;
            end
        endcase
        if (I_CPU_ADDR_ERR) begin
            d.pend_cpu_ae = 1'b1;
        end
        if (I_XFER_ADDR_ERR) begin
            d.pend_xfr_ae = 1'b1;
        end
        if (I_DECODE_VALID && I_INT_REQ) begin
            d.pend_irq = 1'b1;
        end
        if (I_VBR_WE && q.st == CES_IDLE) begin
            d.vector_base_reg = I_VBR_WDATA;
        end
        // resets override the step, bus, pending events and strobes but not a same-cycle base write; peripherals only on power-on
        if (!I_POWER_ON_RESET_PIN_N || (!I_MANUAL_RESET_PIN_N && !po_rise)) begin
            d.st = CES_RST_HOLD;
            d.periph_rst = !I_POWER_ON_RESET_PIN_N;
            d.mreq = 1'b0;
            d.mwe = 1'b0;
            d.pend_cpu_ae = 1'b0;
            d.pend_xfr_ae = 1'b0;
            d.pend_irq = 1'b0;
            d.ctx_load = 1'b0;
            d.int_ack = 1'b0;
        // start fetch on the rising pin
        end else if (po_rise || mr_rise) begin
            d.st = CES_RD_PC;
            d.periph_rst = 1'b0;
            d.kind_rst = 1'b1;
            d.kind_irq = 1'b0;
            d.kind_manual_reset_pin_n = !po_rise;
            d.addr = po_rise ? `CES_PO_PC_ADDR : `CES_MR_PC_ADDR;
            d.mreq = 1'b1;
            d.mwe = 1'b0;
            d.pend_cpu_ae = 1'b0;
            d.pend_xfr_ae = 1'b0;
            d.pend_irq = 1'b0;
            d.ctx_load = 1'b0;
            d.int_ack = 1'b0;
        end
    end

    // state register; comes up holding as if in power-on reset
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            q <= '{st: CES_RST_HOLD, vector_base_reg: `CES_VBR_RESET, sw: `CES_SW_RESET,
                   periph_rst: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs
    assign O_INT_ACK = q.int_ack;
    assign O_MEM_REQ = q.mreq;
    assign O_MEM_WE = q.mwe;
    assign O_MEM_ADDR = q.addr;
    assign O_MEM_WDATA = q.wdata;
    assign O_BUSY = q.st != CES_IDLE;
    assign O_CPU_INIT = q.st == CES_RST_HOLD;
    assign O_PERIPH_RESET = q.periph_rst;
    assign O_CTX_LOAD = q.ctx_load;
    assign O_NEW_PC = q.pc;
    assign O_NEW_SP = q.sp;
    assign O_CPU_STATUS_WORD = q.sw;
    assign O_VECTOR_BASE_REG = q.vector_base_reg;

    // checks; a stalled bus makes timing unbounded, so relations are tied to acks
    property p_po_start;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        po_rise |=> O_MEM_REQ && !O_MEM_WE && O_MEM_ADDR == `CES_PO_PC_ADDR;
    endproperty
    a_po_start: assert property (p_po_start) else $error("power-on fetch not at pc slot");

    property p_mr_start;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (mr_rise && q.po_prev) |=> O_MEM_ADDR == `CES_MR_PC_ADDR && q.st == CES_RD_PC;
    endproperty
    a_mr_start: assert property (p_mr_start) else $error("manual reset fetch wrong");

    property p_rst_ctx;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (q.st == CES_RD_SP && I_MEM_ACK && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N)
        |=> O_CTX_LOAD && O_VECTOR_BASE_REG == `CES_VBR_RESET
            && O_CPU_STATUS_WORD[`CES_MASK_HI:`CES_MASK_LO] == `CES_MASK_ALL
            && O_NEW_SP == $past(I_MEM_RDATA);
    endproperty
    a_rst_ctx: assert property (p_rst_ctx) else $error("reset context wrong");

    property p_push;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        $rose(O_MEM_WE)
        |-> O_MEM_ADDR == $past(I_STACK_POINTER_GPR) - `CES_SP_STEP
            && O_MEM_WDATA == $past(I_CPU_STATUS_WORD);
    endproperty
    a_push: assert property (p_push) else $error("status push wrong");

    property p_irq_mask;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (O_CTX_LOAD && !q.kind_rst && q.kind_irq)
        |-> O_CPU_STATUS_WORD[`CES_MASK_HI:`CES_MASK_LO] == q.lvl;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt level not in mask");

    property p_keep_mask;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (q.st == CES_RD_VEC && I_MEM_ACK && !q.kind_irq && I_POWER_ON_RESET_PIN_N
         && I_MANUAL_RESET_PIN_N)
        |=> O_CPU_STATUS_WORD == $past(q.sw) && O_NEW_PC == $past(I_MEM_RDATA);
    endproperty
    a_keep_mask: assert property (p_keep_mask) else $error("mask changed on exception");

    property p_vec_addr;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (q.st == CES_RD_VEC) |-> O_MEM_ADDR == q.vector_base_reg + {22'h000000, q.vec, 2'h0};
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

    property p_rank;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (q.st == CES_IDLE && q.pend_cpu_ae && I_INSTR_DONE && I_TRAP_EXEC
         && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N && q.mr_prev)
        |=> q.vec == `CES_VEC_CPU_AERR;
    endproperty
    a_rank: assert property (p_rank) else $error("address error lost to trap");

    property p_trap_rank;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (q.st == CES_IDLE && !q.pend_cpu_ae && !q.pend_xfr_ae && !q.pend_irq && I_TRAP_EXEC
         && I_POWER_ON_RESET_PIN_N && I_MANUAL_RESET_PIN_N && q.mr_prev)
        |=> q.vec == $past(I_TRAP_VECTOR) && q.st == CES_PUSH_SW;
    endproperty
    a_trap_rank: assert property (p_trap_rank) else $error("trap not taken first");

    property p_boundary;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        O_INT_ACK |-> $past(I_INSTR_DONE) && $past(q.st) == CES_IDLE;
    endproperty
    a_boundary: assert property (p_boundary) else $error("interrupt taken mid instruction");

    property p_periph;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        (!I_MANUAL_RESET_PIN_N && I_POWER_ON_RESET_PIN_N && q.po_prev) |=> !O_PERIPH_RESET;
    endproperty
    a_periph: assert property (p_periph) else $error("manual reset hit peripherals");

    c_po_done: cover property (@(posedge I_SYS_CLK) q.st == CES_RD_SP && I_MEM_ACK);
    c_irq_take: cover property (@(posedge I_SYS_CLK) O_INT_ACK);
    c_slot: cover property (@(posedge I_SYS_CLK) q.st == CES_PUSH_SW && q.vec == `CES_VEC_SLOT_ILL);
    c_handler: cover property (@(posedge I_SYS_CLK) O_CTX_LOAD && !q.kind_rst);

endmodule

// ===== bench/ces_mem_model.sv
`timescale 1ns/100ps
// memory on the far side of the sequencer's bus, prompt or slow
module ces_mem_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // cycles of stall before each answer
    input  wire logic [3:0]  i_wait,
    // memory bus
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    logic [3:0] cnt;

    // one answer per access; contents derived from the address
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack   <= 1'b0;
            o_rdata <= 32'h0;
            cnt     <= 4'h0;
        end else begin
            o_ack   <= 1'b0;
            // data toggles outside ack so a stale read never matches
            o_rdata <= ~o_rdata;
            if (i_req && !o_ack) begin
                if (cnt >= i_wait) begin
                    o_ack   <= 1'b1;
                    o_rdata <= {~i_addr[15:0], i_addr[15:0]};
                    cnt     <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ===== bench/ces_seq_bench.sv
`timescale 1ns/100ps
module ces_seq_bench;
    // flags: cae xae irq trap und slot pcm
    typedef struct packed {
        logic [6:0] f;
        logic [1:0] kind;
        logic [2:0] ln;
        logic [3:0] lvl;
        logic [7:0] vec;
        logic [3:0] msk;
    } ces_row_t;
    localparam logic [31:0] SP = 32'h00008000;
    localparam logic [31:0] PC = 32'h00002468;
    localparam logic [31:0] SW = 32'h00000030;
    localparam logic [31:0] VB = 32'h00001000;
    logic        clk = 1'b0, rstn = 1'b0, po_n = 1'b0, mr_n = 1'b1;
    logic        done = 1'b0, dv = 1'b0, und = 1'b0, slot = 1'b0, pcm = 1'b0;
    logic        trap = 1'b0, vbr_we = 1'b0, cae = 1'b0, xae = 1'b0, ireq = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic [2:0]  line = 3'h0;
    logic [3:0]  lvl = 4'h0, wt = 4'h2;
    logic [31:0] vbr_wd = 32'h0;
    logic        int_ack, req, we, busy, init, prst, ctx, mack, ack_seen = 1'b0;
    logic [31:0] maddr, mwd, rdata, npc, nsp, nsw, nvbr;
    logic [64:0] log_q[$];
    int          errors = 0;
    int          n_tests = 0;

    ces_seq uut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_POWER_ON_RESET_PIN_N(po_n),
        .I_MANUAL_RESET_PIN_N(mr_n), .I_INSTR_DONE(done), .I_DECODE_VALID(dv),
        .I_DECODE_UNDEFINED(und), .I_DECODE_IN_SLOT(slot), .I_DECODE_PC_MODIFY(pcm),
        .I_TRAP_EXEC(trap), .I_TRAP_VECTOR(8'h21), .I_RETURN_PC(PC), .I_CPU_STATUS_WORD(SW),
        .I_STACK_POINTER_GPR(SP), .I_VBR_WE(vbr_we), .I_VBR_WDATA(vbr_wd),
        .I_CPU_ADDR_ERR(cae), .I_XFER_ADDR_ERR(xae), .I_INT_REQ(ireq), .I_INT_KIND(kind),
        .I_INT_LINE(line), .I_INT_PERIPH_VEC(8'h50), .I_INT_LEVEL(lvl), .O_INT_ACK(int_ack),
        .O_MEM_REQ(req), .O_MEM_WE(we), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwd),
        .I_MEM_ACK(mack), .I_MEM_RDATA(rdata), .O_BUSY(busy), .O_CPU_INIT(init),
        .O_PERIPH_RESET(prst), .O_CTX_LOAD(ctx), .O_NEW_PC(npc), .O_NEW_SP(nsp),
        .O_CPU_STATUS_WORD(nsw), .O_VECTOR_BASE_REG(nvbr));

    ces_mem_model mem (.i_clk(clk), .i_resetn(rstn), .i_wait(wt), .i_req(req),
        .i_addr(maddr), .o_ack(mack), .o_rdata(rdata));

    always #5 clk = ~clk;

    // log finished accesses; the request is held until its ack
    always @(posedge clk) begin
        if (req && mack) log_q.push_back({we, maddr, mwd});
        if (int_ack) begin
            ack_seen <= 1'b1;
            ireq     <= 1'b0;
        end
    end

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction

    task automatic chk(input string nm, input logic [64:0] exp, input logic [64:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wait_ctx;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (ctx !== 1'b1 && k < 300);
        chk("ctx_load", 1, ctx);
    endtask

    // reset fetch: pc then sp from fixed slots, no base
    task automatic chk_reset(input logic [31:0] a);
        wait_ctx();
        chk("log_n", 2, log_q.size());
        if (log_q.size() == 2) begin
            chk("rd_pc", {1'b0, a}, log_q[0][64:32]);
            chk("rd_sp", {1'b0, a + 32'h4}, log_q[1][64:32]);
        end
        chk("new_pc", pat(a), npc);
        chk("new_sp", pat(a + 32'h4), nsp);
        chk("vbr", 0, nvbr);
        chk("mask", 4'hF, nsw[7:4]);
        chk("init", 0, init);
        $display("test reset at %h done, errors %0d", a, errors);
    endtask

    task automatic fire(input ces_row_t r);
        @(posedge clk);
        log_q.delete();
        ack_seen <= 1'b0;
        cae      <= r.f[6];
        xae      <= r.f[5];
        dv       <= r.f[4];
        if (r.f[4]) ireq <= 1'b1;
        kind     <= r.kind;
        line     <= r.ln;
        lvl      <= r.lvl;
        @(posedge clk);
        cae  <= 1'b0;
        xae  <= 1'b0;
        done <= 1'b1;
        trap <= r.f[3];
        dv   <= r.f[2] | r.f[0];
        und  <= r.f[2];
        slot <= r.f[1];
        pcm  <= r.f[0];
        @(posedge clk);
        {done, trap, dv, und, slot, pcm} <= 6'h00;
    endtask

    task automatic expect_take(input ces_row_t r);
        logic [31:0] va;
        va = VB + {22'h0, r.vec, 2'b00};
        wait_ctx();
        chk("log_n", 3, log_q.size());
        if (log_q.size() == 3) begin
            chk("push_sw", {1'b1, SP - 32'h4, SW}, log_q[0]);
            chk("push_pc", {1'b1, SP - 32'h8, PC}, log_q[1]);
            chk("rd_vec", {1'b0, va}, log_q[2][64:32]);
        end
        chk("new_pc", pat(va), npc);
        chk("new_sp", SP - 32'h8, nsp);
        chk("mask", r.msk, nsw[7:4]);
        // only the interrupt rows carry a level other than the saved mask
        chk("int_ack", r.msk != 4'h3, ack_seen);
        $display("test vector %h done, errors %0d", r.vec, errors);
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hang never reaches the end of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        ces_row_t rows [14];
        ces_row_t r;
        rows = '{
            '{7'b1000000, 2'h0, 3'h0, 4'h0, 8'h09, 4'h3}, '{7'b0100000, 2'h0, 3'h0, 4'h0, 8'h0A, 4'h3},
            '{7'b0010000, 2'h0, 3'h0, 4'hF, 8'h0B, 4'hF}, '{7'b0010000, 2'h1, 3'h0, 4'h7, 8'h0C, 4'h7},
            '{7'b0010000, 2'h2, 3'h5, 4'h2, 8'h45, 4'h2}, '{7'b0010000, 2'h3, 3'h0, 4'h9, 8'h50, 4'h9},
            '{7'b0001000, 2'h0, 3'h0, 4'h0, 8'h21, 4'h3}, '{7'b0000100, 2'h0, 3'h0, 4'h0, 8'h04, 4'h3},
            '{7'b0000110, 2'h0, 3'h0, 4'h0, 8'h06, 4'h3}, '{7'b0000011, 2'h0, 3'h0, 4'h0, 8'h06, 4'h3},
            '{7'b0001100, 2'h0, 3'h0, 4'h0, 8'h21, 4'h3}, '{7'b1111100, 2'h0, 3'h0, 4'h8, 8'h09, 4'h3},
            '{7'b0000000, 2'h0, 3'h0, 4'h8, 8'h0A, 4'h3}, '{7'b0000000, 2'h0, 3'h0, 4'h8, 8'h0B, 4'h8}};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("prst", 1, prst);
        chk("init", 1, init);
        @(posedge clk);
        po_n <= 1'b1;
        chk_reset(32'h00000000);
        @(posedge clk);
        vbr_we <= 1'b1;
        vbr_wd <= VB;
        @(posedge clk);
        vbr_we <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            wt <= 4'(i % 3);
            fire(rows[i]);
            expect_take(rows[i]);
        end
        // pending address error waits for the instruction to end
        @(posedge clk);
        cae <= 1'b1;
        @(posedge clk);
        cae <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("busy", 0, busy);
        r = rows[0];
        r.f = 7'b0000000;
        fire(r);
        expect_take(r);
        // manual reset leaves peripherals alone
        @(posedge clk);
        log_q.delete();
        mr_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("prst", 0, prst);
        chk("init", 1, init);
        @(posedge clk);
        mr_n <= 1'b1;
        chk_reset(32'h00000008);
        // second power-on reset in mid-run
        @(posedge clk);
        log_q.delete();
        po_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("prst", 1, prst);
        @(posedge clk);
        po_n <= 1'b1;
        chk_reset(32'h00000000);
        conclude();
    end
endmodule
